// file: rtl/gsc_global_regs.sv
// global interrupt masking, per-port summary and serial io control slice
//
// How it works
// RL1: global mask bit 31 gates lookup engine interrupt; 1 disables; resets to 0.
// RL2: global mask bit 30 gates trigger/timestamp interrupt; 1 disables; resets to 0.
// RL3: each global mask bit enables its matching global status bit as interrupt.
// RL4: read-only port summary bits 0..2 for ports 1..3, reset 0.
// RL5: each port summary bit summarises its detail, enabled by port mask bit.
// RL6: port mask bits 0..2 read/write, 0 enables, reset 0, upper bits reserved.
// RL7: port summary bits derive from the detailed port interrupt status inputs.
// RL8: suppress bit 0 means management frames need a preamble to be accepted.
// RL9: suppress bit 1 means management frames are accepted without preamble.
// RL10: preamble suppression touches only the management mdio path, not spi.
// RL11: auto edge on: drive serial data out rising when clock fast, else falling.
// RL12: auto edge off: bit 0 picks the edge; auto on: bit 0 ignored.
// RL13: manual edge bit 0 selects falling edge, 1 selects rising edge.
// RL14: global status reports lookup engine in bit 31, trigger unit in bit 30.
// RL15: interrupt output high while any unmasked status bit is set.
`timescale 1ns/1ps
`default_nettype none

module gsc_global_regs #(
   parameter int DETAIL_W = 8,
   parameter int PREAMBLE_BITS = gsc_pkg::GSC_PREAMBLE_BITS,
   parameter int FAST_EDGES = gsc_pkg::GSC_FAST_EDGES
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // register access from the management front end
   input wire logic [gsc_pkg::GSC_ADDR_W-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [gsc_pkg::GSC_DATA_W-1:0] i_reg_wdata,
   output logic [gsc_pkg::GSC_DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // interrupt sources
   input wire logic i_lookup_engine_irq,
   input wire logic i_trigger_ts_irq,
   input wire logic [DETAIL_W-1:0] i_port1_detail,
   input wire logic [DETAIL_W-1:0] i_port2_detail,
   input wire logic [DETAIL_W-1:0] i_port3_detail,
   output logic o_irq,
   // management mdio path, bits from the mdio engine
   input wire logic i_mdio_bit_valid,
   input wire logic i_mdio_bit,
   input wire logic i_mdio_frame_start,
   output logic o_mdio_frame_accept,
   output logic o_mdio_frame_reject,
   // spi data out on the serial clock domain
   input wire logic i_link_clk,
   input wire logic i_tx_data,
   output logic o_serial_data_out
);
   import gsc_pkg::*;

   localparam int PRE_W = $clog2(PREAMBLE_BITS + 1);
   localparam int WIN_W = $clog2(GSC_WIN_CYC + 1);
   localparam logic [PRE_W-1:0] PRE_FULL = PRE_W'(PREAMBLE_BITS);
   localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(GSC_WIN_CYC - 1);
   localparam logic [GSC_EDGE_CNT_W-1:0] EDGE_MAX = '1;
   localparam logic [GSC_EDGE_CNT_W-1:0] EDGE_FAST = GSC_EDGE_CNT_W'(FAST_EDGES);

   // true when a register access hits the given offset
   function automatic logic hit(input logic [GSC_ADDR_W-1:0] addr,
                                input logic [GSC_ADDR_W-1:0] off);
      hit = (addr == off);
   endfunction

   // ---------------- reset release ----------------
   logic rst_s1_q;
   logic rst_n;

   // reset asserts at once, releases after two clock edges
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   // ---------------- registers ----------------
   logic [1:0] gmask_q, gmask_d;
   logic [GSC_NUM_PORTS-1:0] pmask_q, pmask_d;
   logic [GSC_SIO_W-1:0] sio_q, sio_d;
   logic [1:0] gstat_q, gstat_d;
   logic [GSC_NUM_PORTS-1:0] pstat_q, pstat_d;
   logic irq_q, irq_d;
   logic [GSC_DATA_W-1:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   // next values of the register file, status capture and interrupt
   always_comb begin
      gmask_d = gmask_q;
      pmask_d = pmask_q;
      sio_d = sio_q;
      if (i_reg_wr && hit(i_reg_addr, GSC_OFF_GLOBAL_IRQ_MASK)) begin
         gmask_d[1] = i_reg_wdata[GSC_BIT_LOOKUP_ENGINE]; // RL1
         gmask_d[0] = i_reg_wdata[GSC_BIT_TRIGGER_TS]; // RL2
      end
      if (i_reg_wr && hit(i_reg_addr, GSC_OFF_PORT_IRQ_MASK)) begin
         pmask_d = i_reg_wdata[GSC_NUM_PORTS-1:0]; // RL6
      end
      if (i_reg_wr && hit(i_reg_addr, GSC_OFF_SERIAL_IO_CONTROL)) begin
         sio_d = i_reg_wdata[GSC_SIO_W-1:0];
      end
      // status follows its sources: lookup engine in bit 31, trigger in 30
      gstat_d = {i_lookup_engine_irq, i_trigger_ts_irq}; // RL14
      // each port summary is the or of that port's detail
      pstat_d = {|i_port3_detail, |i_port2_detail, |i_port1_detail}; // RL7 RL4
      // mask bit 0 lets the status through
      irq_d = |(gstat_q & ~gmask_q) | |(pstat_q & ~pmask_q); // RL3 RL5 RL15
      // read answers one cycle later; unmapped offsets read zero
      rdata_d = rdata_q;
      rvalid_d = i_reg_rd;
      if (i_reg_rd) begin
         rdata_d = GSC_ZERO_WORD;
         if (hit(i_reg_addr, GSC_OFF_GLOBAL_IRQ_STATUS)) begin
            rdata_d[GSC_BIT_LOOKUP_ENGINE] = gstat_q[1];
            rdata_d[GSC_BIT_TRIGGER_TS] = gstat_q[0];
         end else if (hit(i_reg_addr, GSC_OFF_GLOBAL_IRQ_MASK)) begin
            rdata_d[GSC_BIT_LOOKUP_ENGINE] = gmask_q[1];
            rdata_d[GSC_BIT_TRIGGER_TS] = gmask_q[0];
         end else if (hit(i_reg_addr, GSC_OFF_PORT_IRQ_SUMMARY)) begin
            rdata_d[GSC_NUM_PORTS-1:0] = pstat_q;
         end else if (hit(i_reg_addr, GSC_OFF_PORT_IRQ_MASK)) begin
            rdata_d[GSC_NUM_PORTS-1:0] = pmask_q;
         end else if (hit(i_reg_addr, GSC_OFF_SERIAL_IO_CONTROL)) begin
            rdata_d[GSC_SIO_W-1:0] = sio_q;
         end
      end
   end

   // register file flops, frozen while the clock enable is low
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         gmask_q <= GSC_RST_GLOBAL_MASK;
         pmask_q <= GSC_RST_PORT_MASK;
         sio_q <= GSC_RST_SERIAL_IO;
         gstat_q <= GSC_RST_GLOBAL_MASK;
         pstat_q <= GSC_RST_PORT_STATUS;
         irq_q <= 1'b0;
         rdata_q <= GSC_ZERO_WORD;
         rvalid_q <= 1'b0;
      end else if (i_clk_en) begin
         gmask_q <= gmask_d;
         pmask_q <= pmask_d;
         sio_q <= sio_d;
         gstat_q <= gstat_d;
         pstat_q <= pstat_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign o_reg_rdata = rdata_q;
   assign o_reg_rvalid = rvalid_q;
   assign o_irq = irq_q;

   // ---------------- management preamble check ----------------
   gsc_mdio_state_t mst_q, mst_d;
   logic [PRE_W-1:0] pre_cnt_q, pre_cnt_d;
   logic acc_q, acc_d;
   logic rej_q, rej_d;
   logic suppress;

   // only the mdio path looks at the suppress bit; the spi output does not
   assign suppress = sio_q[GSC_BIT_PREAMBLE_SUPPRESS]; // RL10

   // count consecutive ones ahead of a frame start and judge the frame
   always_comb begin
      mst_d = mst_q;
      pre_cnt_d = pre_cnt_q;
      acc_d = 1'b0;
      rej_d = 1'b0;
      if (i_mdio_frame_start) begin
         if (suppress || mst_q == GSC_MDIO_READY) begin
            acc_d = 1'b1; // RL9
         end else begin
            rej_d = 1'b1; // RL8
         end
         mst_d = GSC_MDIO_HUNT;
         pre_cnt_d = '0;
      end else if (i_mdio_bit_valid) begin
         case (mst_q)
            GSC_MDIO_HUNT: begin
               if (i_mdio_bit) begin
                  mst_d = GSC_MDIO_COUNT;
                  pre_cnt_d = PRE_W'(1);
               end
            end
            GSC_MDIO_COUNT: begin
               if (!i_mdio_bit) begin
                  mst_d = GSC_MDIO_HUNT;
                  pre_cnt_d = '0;
               end else if (pre_cnt_q == PRE_FULL - PRE_W'(1)) begin
                  mst_d = GSC_MDIO_READY;
                  pre_cnt_d = PRE_FULL;
               end else begin
                  pre_cnt_d = pre_cnt_q + PRE_W'(1);
               end
            end
            GSC_MDIO_READY: begin
               // more ones keep the preamble good; a zero outside a start breaks it
               if (!i_mdio_bit) begin
                  mst_d = GSC_MDIO_HUNT;
                  pre_cnt_d = '0;
               end
            end
            default: begin
               mst_d = GSC_MDIO_HUNT;
               pre_cnt_d = '0;
            end
         endcase
      end
   end

   // preamble tracker flops
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         mst_q <= GSC_MDIO_HUNT;
         pre_cnt_q <= '0;
         acc_q <= 1'b0;
         rej_q <= 1'b0;
      end else if (i_clk_en) begin
         mst_q <= mst_d;
         pre_cnt_q <= pre_cnt_d;
         acc_q <= acc_d;
         rej_q <= rej_d;
      end
   end

   assign o_mdio_frame_accept = acc_q;
   assign o_mdio_frame_reject = rej_q;

   // ---------------- measurement window on the device clock ----------------
   logic [WIN_W-1:0] win_cnt_q, win_cnt_d;
   logic win_tgl_q, win_tgl_d;

   // the window level flips every fixed number of device cycles
   always_comb begin
      win_cnt_d = win_cnt_q + WIN_W'(1);
      win_tgl_d = win_tgl_q;
      if (win_cnt_q == WIN_LAST) begin
         win_cnt_d = '0;
         win_tgl_d = ~win_tgl_q;
      end
   end

   // window flops
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_q <= '0;
         win_tgl_q <= 1'b0;
      end else if (i_clk_en) begin
         win_cnt_q <= win_cnt_d;
         win_tgl_q <= win_tgl_d;
      end
   end

   // ---------------- serial clock domain ----------------
   logic lrst_s1_q;
   logic lrst_n;

   // reset release for the serial clock side
   always_ff @(posedge i_link_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lrst_s1_q <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_s1_q <= 1'b1;
         lrst_n <= lrst_s1_q;
      end
   end

   localparam logic [1:0] CFG_RST = {GSC_RST_SERIAL_IO[GSC_BIT_AUTO_EDGE],
      GSC_RST_SERIAL_IO[GSC_BIT_MANUAL_RISE]};

   logic [1:0] cfg_s1_q;
   logic [1:0] cfg_s2_q;
   logic [1:0] cfg_s3_q;
   logic [1:0] cfg_q, cfg_d;
   logic win_s1_q, win_s2_q, win_s3_q;
   logic [GSC_EDGE_CNT_W-1:0] edge_cnt_q, edge_cnt_d;
   logic fast_q, fast_d;
   logic use_rise;

   // edge counting per window; the count decides fast or slow serial clock
   always_comb begin
      edge_cnt_d = edge_cnt_q;
      fast_d = fast_q;
      if (win_s2_q != win_s3_q) begin
         fast_d = (edge_cnt_q >= EDGE_FAST); // RL11
         edge_cnt_d = '0;
      end else if (edge_cnt_q != EDGE_MAX) begin
         edge_cnt_d = edge_cnt_q + GSC_EDGE_CNT_W'(1);
      end
      // the two edge bits cross as a pair: take them once two samples agree
      cfg_d = cfg_q;
      if (cfg_s2_q == cfg_s3_q) begin
         cfg_d = cfg_s2_q;
      end
   end

   // synchronisers for the edge controls and the window, plus measurement flops
   always_ff @(posedge i_link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         cfg_s1_q <= CFG_RST;
         cfg_s2_q <= CFG_RST;
         cfg_s3_q <= CFG_RST;
         cfg_q <= CFG_RST;
         win_s1_q <= 1'b0;
         win_s2_q <= 1'b0;
         win_s3_q <= 1'b0;
         edge_cnt_q <= '0;
         fast_q <= 1'b0;
      end else begin
         cfg_s1_q <= {sio_q[GSC_BIT_AUTO_EDGE], sio_q[GSC_BIT_MANUAL_RISE]};
         cfg_s2_q <= cfg_s1_q;
         cfg_s3_q <= cfg_s2_q;
         cfg_q <= cfg_d;
         win_s1_q <= win_tgl_q;
         win_s2_q <= win_s1_q;
         win_s3_q <= win_s2_q;
         edge_cnt_q <= edge_cnt_d;
         fast_q <= fast_d;
      end
   end

   // auto picks by measured rate; otherwise the manual bit picks
   assign use_rise = cfg_q[1] ? fast_q : cfg_q[0]; // RL12 RL13

   logic out_rise_q;
   logic out_fall_q;

   // data launched on the rising serial clock edge
   always_ff @(posedge i_link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         out_rise_q <= 1'b0;
      end else begin
         out_rise_q <= i_tx_data;
      end
   end

   // data launched on the falling serial clock edge
   always_ff @(negedge i_link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         out_fall_q <= 1'b0;
      end else begin
         out_fall_q <= i_tx_data;
      end
   end

   // pick the launching edge for serial data out
   assign o_serial_data_out = use_rise ? out_rise_q : out_fall_q; // RL11 RL13

endmodule

`default_nettype wire

// file: rtl/gsc_pkg.sv
// package: offsets, field positions, reset values and timing for the global register slice
package gsc_pkg;
   // register offsets
   localparam logic [15:0] GSC_OFF_GLOBAL_IRQ_STATUS = 16'h0010;
   localparam logic [15:0] GSC_OFF_GLOBAL_IRQ_MASK = 16'h0014;
   localparam logic [15:0] GSC_OFF_PORT_IRQ_SUMMARY = 16'h0018;
   localparam logic [15:0] GSC_OFF_PORT_IRQ_MASK = 16'h001c;
   localparam logic [15:0] GSC_OFF_SERIAL_IO_CONTROL = 16'h0100;

   // widths
   localparam int GSC_ADDR_W = 16;
   localparam int GSC_DATA_W = 32;
   localparam int GSC_NUM_PORTS = 3;
   localparam int GSC_SIO_W = 8;

   // global status and mask field positions
   localparam int GSC_BIT_LOOKUP_ENGINE = 31;
   localparam int GSC_BIT_TRIGGER_TS = 30;

   // serial io control field positions
   localparam int GSC_BIT_PREAMBLE_SUPPRESS = 2;
   localparam int GSC_BIT_AUTO_EDGE = 1;
   localparam int GSC_BIT_MANUAL_RISE = 0;

   // reset values
   localparam logic [1:0] GSC_RST_GLOBAL_MASK = 2'h0;
   localparam logic [GSC_NUM_PORTS-1:0] GSC_RST_PORT_MASK = 3'h0;
   localparam logic [GSC_NUM_PORTS-1:0] GSC_RST_PORT_STATUS = 3'h0;
   localparam logic [GSC_SIO_W-1:0] GSC_RST_SERIAL_IO = 8'h42;
   localparam logic [GSC_DATA_W-1:0] GSC_ZERO_WORD = 32'h0000_0000;

   // management preamble length in bits of ones
   localparam int GSC_PREAMBLE_BITS = 32;

   // serial clock rate measurement
   localparam int GSC_CLK_MHZ = 25;
   localparam int GSC_WIN_NS = 320;
   localparam int GSC_WIN_CYC = (GSC_WIN_NS * GSC_CLK_MHZ) / 1000;
   localparam int GSC_FAST_MHZ = 25;
   localparam int GSC_FAST_EDGES = (GSC_WIN_NS * GSC_FAST_MHZ + 999) / 1000;
   localparam int GSC_EDGE_CNT_W = 8;

   // management frame acceptance states
   typedef enum logic [1:0] {
      GSC_MDIO_HUNT,
      GSC_MDIO_COUNT,
      GSC_MDIO_READY
   } gsc_mdio_state_t;
endpackage

// file: tb/gsc_checker.sv
// checker: port-level timing relations of the global register slice
`timescale 1ns/1ps
`default_nettype none
module gsc_checker (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_reg_rd,
   input wire logic [gsc_pkg::GSC_DATA_W-1:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_lookup_engine_irq,
   input wire logic i_trigger_ts_irq,
   input wire logic [7:0] i_port1_detail,
   input wire logic [7:0] i_port2_detail,
   input wire logic [7:0] i_port3_detail,
   input wire logic o_irq,
   input wire logic i_mdio_frame_start,
   input wire logic o_mdio_frame_accept,
   input wire logic o_mdio_frame_reject,
   input wire logic o_serial_data_out
);
   wire logic quiet;
   // no source of any kind requesting
   assign quiet = !i_lookup_engine_irq && !i_trigger_ts_irq &&
      i_port1_detail == 8'h00 && i_port2_detail == 8'h00 && i_port3_detail == 8'h00;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_read_gets_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read strobe without answer");
   a_answer_has_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
      else $error("read answer without read");
   a_rdata_holds: assert property (!o_reg_rvalid |-> $stable(o_reg_rdata))
      else $error("read data moved without read");
   a_irq_quiet_sources: assert property (quiet [*3] |-> !o_irq)
      else $error("interrupt with no source");
   a_irq_has_source: assert property (o_irq |-> !$past(quiet, 2))
      else $error("interrupt without source two cycles back");
   a_frame_gets_verdict: assert property (i_mdio_frame_start |=>
      (o_mdio_frame_accept ^ o_mdio_frame_reject))
      else $error("frame start without one verdict");
   a_verdict_has_start: assert property ((o_mdio_frame_accept || o_mdio_frame_reject) |->
      $past(i_mdio_frame_start))
      else $error("frame verdict without start");
   a_reset_clears_out: assert property (disable iff (1'b0) !i_reset_n |->
      !o_irq && !o_reg_rvalid && !o_mdio_frame_accept && !o_serial_data_out)
      else $error("outputs active in reset");
endmodule
bind gsc_global_regs gsc_checker u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_lookup_engine_irq(i_lookup_engine_irq), .i_trigger_ts_irq(i_trigger_ts_irq),
   .i_port1_detail(i_port1_detail), .i_port2_detail(i_port2_detail),
   .i_port3_detail(i_port3_detail), .o_irq(o_irq), .i_mdio_frame_start(i_mdio_frame_start),
   .o_mdio_frame_accept(o_mdio_frame_accept), .o_mdio_frame_reject(o_mdio_frame_reject),
   .o_serial_data_out(o_serial_data_out));
`default_nettype wire

// file: tb/gsc_host_model.sv
// host model: serial clock and the data bit sent on each of its edges
`timescale 1ns/1ps
`default_nettype none
module gsc_host_model (
   input wire logic i_run,
   output logic o_link_clk,
   output logic o_tx_data,
   output logic o_cap_rise,
   output logic o_cap_fall
);
   // clock stands still low outside transfers, phase unrelated to device clock
   initial begin
      o_link_clk = 1'b0;
      o_tx_data = 1'b0;
      o_cap_rise = 1'b0;
      o_cap_fall = 1'b0;
      #3.3;
      forever begin
         #7.5;
         if (i_run || o_link_clk) o_link_clk = ~o_link_clk;
      end
   end
   // note the bit present at each edge, then set it to a fresh random bit, so the two copies can differ
   always @(posedge o_link_clk) begin
      o_cap_rise = o_tx_data;
      #1 o_tx_data = 1'($urandom);
   end
   always @(negedge o_link_clk) begin
      o_cap_fall = o_tx_data;
      #1 o_tx_data = 1'($urandom);
   end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// testbench: registers, interrupts, mdio preamble and spi output edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import gsc_pkg::*;
   localparam int PB = 8;
   logic i_clk = 0, i_reset_n = 1, rd = 0, wr = 0, le_src = 0, trg = 0;
   logic bv = 0, bit_v = 0, fs = 0, run = 1, en = 1;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [7:0] d1 = 8'h00, d2 = 8'h00, d3 = 8'h00;
   logic rvalid, irq, acc, rej, lclk, txd, sout, cap_r, cap_f;
   logic [31:0] rq [$];
   logic fq [$];
   int num_errors = 0;
   int n_tests = 0;
   always #20 i_clk = ~i_clk;
   gsc_global_regs #(.PREAMBLE_BITS(PB)) DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_clk_en(en), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_lookup_engine_irq(le_src),
      .i_trigger_ts_irq(trg), .i_port1_detail(d1), .i_port2_detail(d2), .i_port3_detail(d3),
      .o_irq(irq), .i_mdio_bit_valid(bv), .i_mdio_bit(bit_v), .i_mdio_frame_start(fs),
      .o_mdio_frame_accept(acc), .o_mdio_frame_reject(rej), .i_link_clk(lclk),
      .i_tx_data(txd), .o_serial_data_out(sout));
   gsc_host_model host (.i_run(run), .o_link_clk(lclk), .o_tx_data(txd),
      .o_cap_rise(cap_r), .o_cap_fall(cap_f));
   task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(string nm, logic e, logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic reg_wr(logic [15:0] a, logic [31:0] d);
      cyc(1);
      addr = a;
      wdata = d;
      wr = 1;
      cyc(1);
      wr = 0;
   endtask
   task automatic reg_rd(logic [15:0] a, logic [31:0] e);
      cyc(1);
      addr = a;
      rd = 1;
      rq.push_back(e);
      cyc(1);
      rd = 0;
   endtask
   // ones, an optional zero, then a frame start whose verdict is noted
   task automatic mdio(int ones, logic tail_zero, logic exp);
      for (int i = 0; i < ones + int'(tail_zero); i++) begin
         bv = 1;
         bit_v = (i < ones);
         cyc(1);
      end
      bv = 0;
      fs = 1;
      fq.push_back(exp);
      cyc(1);
      fs = 0;
      cyc(1);
   endtask
   task automatic set_src(int k, logic v);
      logic [7:0] d;
      d = v ? (8'($urandom) | 8'h01) : 8'h00;
      case (k)
         0: le_src = v;
         1: trg = v;
         2: d1 = d;
         3: d2 = d;
         default: d3 = d;
      endcase
   endtask
   // results that carry a strobe are taken off the queues as they appear
   always @(negedge i_clk) begin
      if (rvalid === 1'b1) chk_word("read data", rq.pop_front(), rdata);
      if ((acc | rej) === 1'b1) chk_bit("frame accept", fq.pop_front(), acc);
   end
   initial begin
      #200_000;
      num_errors++;
      final_report;
   end
   initial begin
      logic [15:0] a, m;
      logic [31:0] b, r;
      logic [7:0] sio [4] = '{8'h44, 8'h01, 8'h00, 8'h03};
      logic rise [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
      void'($urandom(32'hb91bb5bf));
      #1 i_reset_n = 0;
      repeat (5) @(posedge i_clk);
      #1 i_reset_n = 1;
      run = 0;
      cyc(3);
      reg_rd(GSC_OFF_GLOBAL_IRQ_MASK, 32'h0);
      reg_rd(GSC_OFF_PORT_IRQ_SUMMARY, 32'h0);
      reg_rd(GSC_OFF_PORT_IRQ_MASK, 32'h0);
      reg_rd(GSC_OFF_SERIAL_IO_CONTROL, 32'h42);
      reg_rd(16'h0200, 32'h0);
      repeat (4) begin
         r = $urandom;
         reg_wr(GSC_OFF_GLOBAL_IRQ_MASK, r);
         reg_rd(GSC_OFF_GLOBAL_IRQ_MASK, r & 32'hc000_0000);
         reg_wr(GSC_OFF_PORT_IRQ_MASK, r);
         reg_rd(GSC_OFF_PORT_IRQ_MASK, r & 32'h0000_0007);
         reg_wr(GSC_OFF_GLOBAL_IRQ_STATUS, r);
         reg_rd(GSC_OFF_GLOBAL_IRQ_STATUS, 32'h0);
         reg_wr(GSC_OFF_PORT_IRQ_SUMMARY, r);
         reg_rd(GSC_OFF_PORT_IRQ_SUMMARY, 32'h0);
         reg_wr(GSC_OFF_SERIAL_IO_CONTROL, r);
         reg_rd(GSC_OFF_SERIAL_IO_CONTROL, r & 32'h0000_00ff);
      end
      reg_wr(GSC_OFF_GLOBAL_IRQ_MASK, 32'h0);
      reg_wr(GSC_OFF_PORT_IRQ_MASK, 32'h0);
      reg_wr(GSC_OFF_SERIAL_IO_CONTROL, 32'h42);
      // with the clock enable low neither a write nor a new source may land
      en = 0;
      set_src(0, 1);
      reg_wr(GSC_OFF_GLOBAL_IRQ_MASK, 32'hc000_0000);
      chk_bit("irq frozen", 1'b0, irq);
      en = 1;
      reg_rd(GSC_OFF_GLOBAL_IRQ_MASK, 32'h0);
      chk_bit("irq after enable", 1'b1, irq);
      set_src(0, 0);
      cyc(3);
      $display("register access test done");
      for (int k = 0; k < 5; k++) begin
         a = k < 2 ? GSC_OFF_GLOBAL_IRQ_STATUS : GSC_OFF_PORT_IRQ_SUMMARY;
         m = k < 2 ? GSC_OFF_GLOBAL_IRQ_MASK : GSC_OFF_PORT_IRQ_MASK;
         b = k < 2 ? 32'h1 << (31 - k) : 32'h1 << (k - 2);
         set_src(k, 1);
         cyc(2);
         chk_bit("irq unmasked", 1'b1, irq);
         reg_wr(m, b);
         cyc(2);
         chk_bit("irq masked", 1'b0, irq);
         reg_rd(a, b);
         reg_wr(m, 32'h0);
         cyc(2);
         chk_bit("irq unmasked again", 1'b1, irq);
         set_src(k, 0);
         cyc(3);
         chk_bit("irq cleared", 1'b0, irq);
      end
      $display("interrupt test done");
      mdio(PB, 1'b0, 1'b1);
      mdio(PB - 1, 1'b0, 1'b0);
      mdio(PB, 1'b1, 1'b0);
      mdio(0, 1'b0, 1'b0);
      reg_wr(GSC_OFF_SERIAL_IO_CONTROL, 32'h46);
      mdio(0, 1'b0, 1'b1);
      mdio(3, 1'b1, 1'b1);
      $display("mdio preamble test done");
      run = 1;
      for (int j = 0; j < 4; j++) begin
         reg_wr(GSC_OFF_SERIAL_IO_CONTROL, {24'h0, sio[j]});
         cyc(40);
         repeat (4) begin
            @(posedge lclk);
            #2 chk_bit("serial data out", rise[j] ? cap_r : cap_f, sout);
         end
      end
      run = 0;
      $display("spi edge test done");
      cyc(3);
      chk_word("pending results", 32'h0, 32'(rq.size() + fq.size()));
      final_report;
   end
endmodule
`default_nettype wire
